// File: csp_params.svh
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// source clock rate
`define CSP_CLK_MHZ 25
// register indices, byte address is four times the index
`define CSP_IDX_PRESCALE 8'h26
`define CSP_IDX_STATUS 8'h27
`define CSP_IDX_CONTROL 8'h28
// prescale register fields
`define CSP_UNLOCK_BIT 7
`define CSP_DIV_RST_DIV8 4'h3
`define CSP_DIV_RST_NONE 4'h0
`define CSP_DIV_MAX_CODE 4'h8
`define CSP_UNLOCK_CYC 4
// fuse codes, zero means programmed
`define CSP_SRC_LF_XTAL 4'h6
// start-up counts in source cycles
`define CSP_CK_6 6
`define CSP_CK_14 14
`define CSP_CK_258 258
`define CSP_CK_1K 1024
`define CSP_CK_16K 16384
`define CSP_CK_32K 32768
// real-time delays in microseconds and their cycle counts
`define CSP_T_4MS_US 4000
`define CSP_T_64MS_US 64000
`define CSP_T_BRN_US 60
`define CSP_CYC_4MS (`CSP_T_4MS_US * `CSP_CLK_MHZ)
`define CSP_CYC_64MS (`CSP_T_64MS_US * `CSP_CLK_MHZ)
`define CSP_CYC_BRN (`CSP_T_BRN_US * `CSP_CLK_MHZ)
// control and status bits
`define CSP_CTL_BRN_OFF_BIT 0
`define CSP_STS_RUN_BIT 0
`define CSP_STS_BAD_CFG_BIT 1
`define CSP_STS_BUSY_BIT 2

`endif

// File: csp_pkg.sv
package csp_pkg;
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN = 2'b10,
        ST_SLEEP = 2'b11
    } csp_state_t;
    typedef enum logic [1:0] {
        DLY_NONE = 2'b00,
        DLY_4MS = 2'b01,
        DLY_64MS = 2'b10
    } csp_ms_t;
endpackage : csp_pkg

// File: csp_clock_ctrl.sv
// Functional notes
// - source code 0110 selects the low-frequency watch crystal
// - low-frequency crystal start-up codes set wake and reset delay; 11 reserved
// - upper three source bits pick crystal amplifier frequency range
// - lowest source bit plus start-up code sets crystal wake delay
// - crystal mode reset delay is 14CK, plus nothing (codes 2 and 5), 4 ms or 64 ms per code
// - brown-out detector off stretches wake-up to about 60 us
// - factory fuses give internal RC source divided by eight
// - CPU, I/O, ADC and flash clocks share one division factor
// - division change is glitch free, never faster than old or new
// - prescaler counts undivided source clock; count state not readable
// - new rate active after T1+T2 to T1+2*T2, two edges between
// - output fuse drives system clock on output pin, any source
// - clock output pin stays quiet during reset
// - output pin carries the divided system clock
// - division codes 0 to 8 give factors 1 to 256, others reserved
// - unlock write first, new value within four cycles, unlock self-clears
// - division field resets to 0011 with divide-by-eight fuse, else 0000
`timescale 1ns/100ps
`include "csp_params.svh"

module csp_clock_ctrl #(
    parameter int CK_16K = `CSP_CK_16K,
    parameter int CK_32K = `CSP_CK_32K,
    parameter int CYC_4MS = `CSP_CYC_4MS,
    parameter int CYC_64MS = `CSP_CYC_64MS
) (
    input wire logic MCLK, // undivided source clock
    input wire logic RSTN, // async reset, active low
    input wire logic [7:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read request
    input wire logic AVS_WRITE, // write request
    input wire logic [31:0] AVS_WRITEDATA, // write data
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall
    input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSES, // source select fuses
    input wire logic [1:0] STARTUP_TIME_FUSES, // start-up fuses
    input wire logic INITIAL_DIVIDE_BY_EIGHT_FUSE, // 0 = programmed
    input wire logic CLOCK_OUTPUT_FUSE, // 0 = programmed
    input wire logic SLEEP_REQ, // power-down while high
    output logic [2:0] OSCILLATOR_RANGE_SELECT, // amplifier range
    output logic CPU_CLK_EN, // cpu clock enable
    output logic IO_CLK_EN, // io clock enable
    output logic ADC_CLK_EN, // adc clock enable
    output logic FLASH_CLK_EN, // flash clock enable
    output logic SYS_CLK, // divided system clock
    output logic CLOCK_OUTPUT_PIN_OUT, // output pin level
    output logic CLOCK_OUTPUT_PIN_OE, // output pin enable
    output logic CORE_RUNNING // clocks released
);
    logic rst_meta_ff;
    logic rst_n;
    csp_pkg::csp_state_t state_ff;
    csp_pkg::csp_state_t nxt_state;
    logic [23:0] dly_ff;
    logic [23:0] nxt_dly;
    logic [3:0] div_sel_ff;
    logic [3:0] div_act_ff;
    logic unlock_ff;
    logic [1:0] unl_cnt_ff;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic div_clk_ff;
    logic brn_off_ff;
    logic ack_ff;
    logic oe_ff;
    logic [2:0] range_ff;
    logic [31:0] rdata_ff;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // fuse decode
    wire [3:0] src = CLOCK_SOURCE_SELECT_FUSES;
    wire [1:0] sut = STARTUP_TIME_FUSES;
    wire is_lf = (src == `CSP_SRC_LF_XTAL);
    wire is_xo = src[3];
    wire [2:0] xo_code = {src[0], sut};
    wire bad_cfg = (!is_xo && src[0]) || (!is_xo && sut == 2'b11);
    wire [23:0] xo_wake = (xo_code <= 3'd1) ? 24'(`CSP_CK_258) :
        (xo_code <= 3'd4) ? 24'(`CSP_CK_1K) : 24'(CK_16K);
    wire [23:0] lf_wake = (sut == 2'b10) ? 24'(CK_32K) : 24'(`CSP_CK_1K);
    wire [23:0] sel_wake = bad_cfg ? 24'(CK_32K) : is_xo ? xo_wake :
        is_lf ? lf_wake : 24'(`CSP_CK_6);
    wire [23:0] wake_ck = (brn_off_ff && sel_wake < 24'(`CSP_CYC_BRN)) ?
        24'(`CSP_CYC_BRN) : sel_wake;
    wire [1:0] xo_ms = (xo_code == 3'd0 || xo_code == 3'd3 || xo_code == 3'd6) ?
        csp_pkg::DLY_4MS : (xo_code == 3'd2 || xo_code == 3'd5) ?
        csp_pkg::DLY_NONE : csp_pkg::DLY_64MS;
    wire [1:0] lf_ms = (sut == 2'b00) ? csp_pkg::DLY_4MS : csp_pkg::DLY_64MS;
    wire [1:0] oth_ms = (sut == 2'b00) ? csp_pkg::DLY_NONE :
        (sut == 2'b01) ? csp_pkg::DLY_4MS : csp_pkg::DLY_64MS;
    wire [1:0] ms_sel = bad_cfg ? csp_pkg::DLY_64MS : is_xo ? xo_ms :
        is_lf ? lf_ms : oth_ms;
    wire [23:0] ms_cyc = (ms_sel == csp_pkg::DLY_4MS) ? 24'(CYC_4MS) :
        (ms_sel == csp_pkg::DLY_64MS) ? 24'(CYC_64MS) : 24'h00_0000;
    wire [23:0] ck14 = is_lf ? 24'h00_0000 : 24'(`CSP_CK_14);
    wire [23:0] rst_total = wake_ck + ck14 + ms_cyc;

    always_comb begin
        nxt_state = state_ff;
        nxt_dly = dly_ff;
        case (state_ff)
            csp_pkg::ST_INIT: begin
                nxt_state = csp_pkg::ST_COUNT;
                nxt_dly = rst_total;
            end
            csp_pkg::ST_COUNT: begin
                if (dly_ff <= 24'h00_0001) begin
                    nxt_state = csp_pkg::ST_RUN;
                end
                nxt_dly = dly_ff - 24'h00_0001;
            end
            csp_pkg::ST_RUN: begin
                if (SLEEP_REQ) begin
                    nxt_state = csp_pkg::ST_SLEEP;
                end
            end
            csp_pkg::ST_SLEEP: begin
                if (!SLEEP_REQ) begin
                    nxt_state = csp_pkg::ST_COUNT;
                    nxt_dly = wake_ck;
                end
            end
            default: begin
                nxt_state = csp_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= csp_pkg::ST_INIT;
            dly_ff <= 24'h00_0000;
        end else begin
            state_ff <= nxt_state;
            dly_ff <= nxt_dly;
        end
    end

    wire run = (state_ff == csp_pkg::ST_RUN);

    // bus slave, one wait cycle per access
    wire req = AVS_READ || AVS_WRITE;
    wire fire_wr = AVS_WRITE && ack_ff;
    wire sel_pre = (AVS_ADDRESS == 8'(`CSP_IDX_PRESCALE * 4));
    wire sel_sts = (AVS_ADDRESS == 8'(`CSP_IDX_STATUS * 4));
    wire sel_ctl = (AVS_ADDRESS == 8'(`CSP_IDX_CONTROL * 4));
    wire [7:0] wd = AVS_WRITEDATA[7:0];
    wire wr_unlock = fire_wr && sel_pre && wd == 8'h80 && !unlock_ff;
    wire wr_div = fire_wr && sel_pre && !wd[`CSP_UNLOCK_BIT] && unlock_ff;
    wire unl_expire = unlock_ff && unl_cnt_ff == 2'(`CSP_UNLOCK_CYC - 1);
    wire [7:0] pre_rd = {unlock_ff, 3'b000, div_sel_ff};
    wire [7:0] sts_rd = {div_act_ff, 1'b0, state_ff != csp_pkg::ST_RUN,
        bad_cfg, run};
    wire [7:0] rd_mux = sel_pre ? pre_rd : sel_sts ? sts_rd :
        sel_ctl ? {7'b000_0000, brn_off_ff} : 8'h00;
    assign AVS_WAITREQUEST = req && !ack_ff;
    assign AVS_READDATA = rdata_ff;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            brn_off_ff <= 1'b0;
        end else begin
            ack_ff <= req && !ack_ff;
            if (AVS_READ && !ack_ff) begin
                rdata_ff <= {24'h00_0000, rd_mux};
            end
            if (fire_wr && sel_ctl) begin
                brn_off_ff <= wd[`CSP_CTL_BRN_OFF_BIT];
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            unlock_ff <= 1'b0;
            unl_cnt_ff <= 2'b00;
        end else begin
            unlock_ff <= wr_unlock || (unlock_ff && !wr_div && !unl_expire);
            unl_cnt_ff <= unlock_ff ? unl_cnt_ff + 2'b01 : 2'b00;
        end
    end

    wire [3:0] div_init = INITIAL_DIVIDE_BY_EIGHT_FUSE ? `CSP_DIV_RST_NONE :
        `CSP_DIV_RST_DIV8;
    // reserved codes fall back to the largest factor
    wire [3:0] div_eff = (div_act_ff > `CSP_DIV_MAX_CODE) ? `CSP_DIV_MAX_CODE :
        div_act_ff;
    wire [8:0] factor = 9'h001 << div_eff;
    wire [7:0] fm1 = 8'(factor - 9'h001);
    wire [7:0] half = 8'(factor >> 1);
    wire tick = run && (cnt_ff == fm1);
    assign nxt_cnt = (!run || tick) ? 8'h00 : cnt_ff + 8'h01;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            div_sel_ff <= `CSP_DIV_RST_NONE;
            div_act_ff <= `CSP_DIV_RST_NONE;
        end else if (state_ff == csp_pkg::ST_INIT) begin
            div_sel_ff <= div_init;
            div_act_ff <= div_init;
        end else begin
            if (wr_div) begin
                div_sel_ff <= wd[3:0];
            end
            // switch only at a period boundary or while not running
            if (tick || !run) begin
                div_act_ff <= div_sel_ff;
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            div_clk_ff <= 1'b0;
            oe_ff <= 1'b0;
            range_ff <= 3'b000;
        end else begin
            cnt_ff <= nxt_cnt;
            // low as soon as running ends, so sleep never leaves the pin high
            div_clk_ff <= (nxt_state == csp_pkg::ST_RUN) && (nxt_cnt < half);
            oe_ff <= !CLOCK_OUTPUT_FUSE;
            range_ff <= is_xo ? src[3:1] : 3'b000;
        end
    end

    assign CPU_CLK_EN = tick;
    assign IO_CLK_EN = tick;
    assign ADC_CLK_EN = tick;
    assign FLASH_CLK_EN = tick;
    // divided clock on the pin, quiet while not running
    wire sys_clk_w = (div_eff == 4'h0) ? (MCLK && run) : div_clk_ff;
    assign SYS_CLK = sys_clk_w;
    assign CLOCK_OUTPUT_PIN_OUT = oe_ff && sys_clk_w;
    assign CLOCK_OUTPUT_PIN_OE = oe_ff;
    assign OSCILLATOR_RANGE_SELECT = range_ff;
    assign CORE_RUNNING = run;

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    sequence unl_open_s;
        $rose(unlock_ff);
    endsequence
    unlock_timeout_a: assert property (unl_open_s |-> ##[1:4] !unlock_ff)
        else $error("unlock bit outlived its window");
    div_reset_a: assert property (state_ff == csp_pkg::ST_INIT && rst_n |=>
        div_sel_ff == (INITIAL_DIVIDE_BY_EIGHT_FUSE ? 4'h0 : 4'h3))
        else $error("division field wrong after reset");
    gated_startup_a: assert property (!run |-> !CPU_CLK_EN && !div_clk_ff)
        else $error("clock released before start-up done");
    wake_count_a: assert property ($fell(SLEEP_REQ) && state_ff == csp_pkg::ST_SLEEP
        |=> state_ff == csp_pkg::ST_COUNT && dly_ff == wake_ck)
        else $error("wake delay not loaded");
    pin_quiet_a: assert property (!run |-> !CLOCK_OUTPUT_PIN_OUT)
        else $error("output pin toggles while held");
    lf_wake_a: assert property (is_lf && sut == 2'b10 && !brn_off_ff
        |-> wake_ck == 24'(CK_32K) && ms_sel == csp_pkg::DLY_64MS)
        else $error("watch crystal delay decode wrong");
    xo_wake_a: assert property (is_xo && xo_code == 3'd5 && !brn_off_ff
        |-> wake_ck == 24'(CK_16K) && ms_cyc == 24'h00_0000)
        else $error("crystal delay decode wrong");
    brn_wake_a: assert property (brn_off_ff |-> wake_ck >= 24'(`CSP_CYC_BRN))
        else $error("wake not stretched");
    div_apply_a: assert property (wr_div |-> ##[1:300] div_act_ff == div_sel_ff)
        else $error("new division never applied");
    pin_divided_a: assert property (tick && oe_ff && div_eff != 4'h0 && div_sel_ff != 4'h0
        && !SLEEP_REQ |=> CLOCK_OUTPUT_PIN_OUT)
        else $error("pin not carrying divided clock");
    tick_space_a: assert property (tick && div_eff == 4'h3 && div_sel_ff == 4'h3 && run
        |=> !tick [*7] ##1 (tick || !run || div_eff != 4'h3))
        else $error("divide by eight spacing wrong");
endmodule : csp_clock_ctrl

// File: csp_clk_load.sv
`timescale 1ns/100ps

// circuit fed from the clock output pin, keeps the last period seen
module csp_clk_load (
    input wire logic clk_in, // resolved pin level
    input wire logic oe, // pin driven
    output time period // last rise-to-rise span
);
    time last_t = 0;

    initial period = 0;

    // loaded only while the pin is driven
    always @(posedge clk_in) begin
        if (oe) begin
            period = $time - last_t;
            last_t = $time;
        end
    end
endmodule : csp_clk_load

// File: clock_source_startup_prescaler_tb.sv
`timescale 1ns/100ps

module clock_source_startup_prescaler_tb;
    localparam logic [7:0] A_PRE = 8'h98;
    localparam logic [7:0] A_STS = 8'h9C;
    localparam logic [7:0] A_CTL = 8'hA0;
    localparam int WAKE = 40;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic slp = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic wq, cpu, io, adc, fl, pout, poe, run, pin, same, sclk;
    logic [2:0] rng;
    logic [3:0] src = 4'hF;
    logic [1:0] sut = 2'h1;
    logic div8 = 1'b0;
    logic cko = 1'b0;
    time per;
    int n_fail = 0;
    int compares = 0;
    int n, f, ne;
    int lf_exp[3] = '{1044, 1074, 110};

    // pulled low when the pin is not driven
    assign pin = poe ? pout : 1'b0;

    initial begin
        forever #20 mclk = ~mclk;
    end

    csp_clock_ctrl #(.CK_16K(WAKE), .CK_32K(60), .CYC_4MS(20), .CYC_64MS(50)) dut_u (
        .MCLK(mclk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
        .CLOCK_SOURCE_SELECT_FUSES(src), .STARTUP_TIME_FUSES(sut),
        .INITIAL_DIVIDE_BY_EIGHT_FUSE(div8), .CLOCK_OUTPUT_FUSE(cko), .SLEEP_REQ(slp),
        .OSCILLATOR_RANGE_SELECT(rng), .CPU_CLK_EN(cpu), .IO_CLK_EN(io), .ADC_CLK_EN(adc),
        .FLASH_CLK_EN(fl), .SYS_CLK(sclk), .CLOCK_OUTPUT_PIN_OUT(pout),
        .CLOCK_OUTPUT_PIN_OE(poe), .CORE_RUNNING(run)
    );

    csp_clk_load load_u (.clk_in(pin), .oe(poe), .period(per));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // one access, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge mclk);
            k++;
        end while (wq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge mclk);
        chk(32'(k), 32'h2, "bus answer");
    endtask : bus

    task automatic wait_run(output int c);
        c = 0;
        while (run !== 1'b1 && c < 5000) begin
            @(negedge mclk);
            c++;
        end
        @(posedge mclk);
    endtask : wait_run

    task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic d8);
        @(posedge mclk);
        rstn <= 1'b0;
        src <= s;
        sut <= t;
        div8 <= d8;
        cko <= d8;
        repeat (16) begin
            @(negedge mclk);
            chk({30'h0, poe, pout}, 32'h0, "pin in reset");
        end
        @(posedge mclk);
        rstn <= 1'b1;
        wait_run(n);
    endtask : do_reset

    initial begin
        do_reset(4'hF, 2'h1, 1'b0);
        chk(32'(n >= WAKE + 14 && n <= WAKE + 19), 32'h1, "crystal startup");
        chk(32'(rng), 32'h7, "amplifier range");
        bus(1'b0, A_PRE, 32'h0);
        chk(q, 32'h0000_0003, "prescale reset");
        repeat (40) @(posedge mclk);
        chk(32'(per), 32'h0000_0140, "pin period div8");
        $display("test crystal start done");
        bus(1'b1, A_PRE, 32'h0000_0001);
        bus(1'b1, A_PRE, 32'h0000_0081);
        bus(1'b1, A_PRE, 32'h0000_0001);
        bus(1'b1, A_PRE, 32'h0000_0080);
        repeat (4) @(posedge mclk);
        bus(1'b1, A_PRE, 32'h0000_0002);
        bus(1'b0, A_PRE, 32'h0);
        chk(q, 32'h0000_0003, "locked prescale");
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0, "unmapped read");
        $display("test unlock done");
        for (int c = 0; c < 10; c++) begin
            f = (c > 8) ? 256 : (1 << c);
            bus(1'b1, A_PRE, 32'h0000_0080);
            bus(1'b1, A_PRE, 32'(c));
            repeat (3 * f + 8) @(posedge mclk);
            bus(1'b0, A_STS, 32'h0);
            chk(32'(q[7:4]), 32'(c), "active code");
            ne = 0;
            same = 1'b1;
            repeat (4 * f) begin
                @(negedge mclk);
                ne += int'(cpu);
                same &= (io === cpu) && (adc === cpu) && (fl === cpu) && (sclk === pout);
            end
            @(posedge mclk);
            chk(32'(ne), 32'h4, "enable pulses");
            chk(32'(same), 32'h1, "domains equal");
            chk(32'(per), 32'(40 * f), "pin period");
            $display("test division code %0d done", c);
        end
        @(posedge mclk);
        for (int b = 0; b < 2; b++) begin
            if (b == 1) begin
                bus(1'b1, A_CTL, 32'h0000_0001);
            end
            slp <= 1'b1;
            repeat (4) @(posedge mclk);
            chk(32'(run), 32'h0, "asleep");
            slp <= 1'b0;
            wait_run(n);
            if (b == 0) begin
                chk(32'(n >= WAKE && n <= WAKE + 4), 32'h1, "wake crystal");
            end else begin
                chk(32'(n >= 1500 && n <= 1600), 32'h1, "wake detector off");
            end
            $display("test sleep %0d done", b);
        end
        for (int t = 0; t < 3; t++) begin
            do_reset(4'h6, 2'(t), 1'b1);
            chk(32'(n >= lf_exp[t] && n <= lf_exp[t] + 5), 32'h1, "watch startup");
            chk(32'(rng), 32'h0, "range off");
            chk(32'(poe), 32'h0, "pin released");
            bus(1'b0, A_PRE, 32'h0);
            chk(q, 32'h0, "prescale no fuse");
            $display("test watch crystal %0d done", t);
        end
        do_reset(4'hA, 2'h2, 1'b1);
        chk(32'(n >= 1038 && n <= 1043), 32'h1, "resonator startup");
        chk(32'(rng), 32'h5, "resonator range");
        $display("test resonator done");
        test_done;
    end

    initial begin
        #2000000;
        n_fail++;
        test_done;
    end
endmodule : clock_source_startup_prescaler_tb
